// ===== rtl/ccs_pkg.sv
// Package: constants, enums and structs of the common command status unit
package ccs_pkg;
    localparam int SLOTS = 10;
    localparam logic [3:0] SLOT_MIN = 4'h1;
    localparam logic [3:0] SLOT_MAX = 4'hA;
    localparam int SETUP_W = 32;
    localparam logic [SETUP_W-1:0] SETUP_DEFAULT = 32'h0000_0000;
    localparam logic [7:0] MASK_RESET = 8'h00;
    localparam logic [7:0] MASK_KEEP = 8'hBF;
    localparam logic [7:0] EVT_RESET = 8'h80;
    localparam int B_DEVDEP = 1;
    localparam int B_QUEUE = 2;
    localparam int B_QUES = 3;
    localparam int B_MAV = 4;
    localparam int B_ESB = 5;
    localparam int B_MSS = 6;
    localparam int B_OPER = 7;
    localparam int E_OPC = 0;
    localparam logic [15:0] ERR_PARAM = 16'hFF20;
    localparam logic [15:0] ERR_TRIG = 16'hFF2D;
    localparam logic [7:0] CH_ONE = 8'h31;
    localparam logic [7:0] CH_ZERO = 8'h30;
    localparam logic [7:0] CH_COMMA = 8'h2C;
    localparam logic [7:0] CH_DOT = 8'h2E;
    localparam logic [7:0] CH_NUL = 8'h00;
    localparam logic [7:0] CH_TWO = 8'h32;
    localparam logic [7:0] CH_THREE = 8'h33;
    localparam real CLK_MHZ = 125.0;
    localparam real TEST_S = 30.0;
    localparam longint TEST_CYC_L = longint'(TEST_S * CLK_MHZ * 1.0e6);
    localparam int TEST_CYC_W = 32;

    typedef enum logic [3:0] {
        CMD_IDN, CMD_OPC, CMD_OPCQ, CMD_OPT, CMD_RCL, CMD_SAV, CMD_RST,
        CMD_SRE, CMD_SREQ, CMD_STBQ, CMD_ESRQ, CMD_TRG, CMD_TSTQ, CMD_WAI,
        CMD_NOP
    } cmd_t;

    typedef enum logic [1:0] {
        OPT_STD, OPT_002, OPT_003
    } option_t;

    typedef struct packed {
        cmd_t cmd;
        logic [7:0] arg;
    } cmd_req_t;

    typedef struct packed {
        logic ques;
        logic oper;
        logic devdep;
        logic evq_nonempty;
        logic mav;
    } status_in_t;

    typedef struct packed {
        logic [15:0] code;
        logic valid;
    } err_t;
endpackage : ccs_pkg

// ===== rtl/ccs_status_byte.sv
// Status byte, master summary and service request mask
`timescale 1ns/10ps
`default_nettype none
module ccs_status_byte (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic mask_we,
    input wire logic [7:0] mask_wdata,
    input wire logic clear_mask,
    input wire ccs_pkg::status_in_t sin,
    input wire logic esb,
    output logic [7:0] mask,
    output logic [7:0] stb,
    output logic mss
);
    logic [7:0] mask_q;
    logic [7:0] raw;

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            mask_q <= ccs_pkg::MASK_RESET;
        else if (clear_mask)
            mask_q <= ccs_pkg::MASK_RESET;
        else if (mask_we)
            mask_q <= mask_wdata & ccs_pkg::MASK_KEEP; // R9 R11
    end

    // Raw status byte with bit 6 empty
    always_comb
    begin
        raw = 8'h00;
        raw[ccs_pkg::B_DEVDEP] = sin.devdep; // R17
        raw[ccs_pkg::B_QUEUE] = sin.evq_nonempty; // R24
        raw[ccs_pkg::B_QUES] = sin.ques; // R16
        raw[ccs_pkg::B_MAV] = sin.mav; // R14
        raw[ccs_pkg::B_ESB] = esb; // R15
        raw[ccs_pkg::B_OPER] = sin.oper; // R17
    end

    assign mask = mask_q;
    assign mss = |(raw & mask_q & ccs_pkg::MASK_KEEP); // R10 R13
    assign stb = raw | ({7'h00, mss} << ccs_pkg::B_MSS); // R12
endmodule : ccs_status_byte
`default_nettype wire

// ===== rtl/ccs_unit.sv
// Common command interpreter with status reporting
//
// Operation
// (R1) Identity query returns maker, model, serial and major.minor firmware text.
// (R2) *OPC sets operation-complete event once all pending operations finish.
// (R3) *OPC? queues ASCII 1 only after pending operations finish.
// (R4) Option query returns empty, 002 or 003 per installed option; with no option the code sends one NUL byte.
// (R5) Recall restores full setup from slot 1 to 10.
// (R6) Recall of an empty slot is rejected with error -224.
// (R7) Save copies current setup into slot 1 to 10, overwriting it.
// (R8) Reset puts all settings into fixed defaults.
// (R9) Mask write stores bits 0-5 and 7; bit 6 stays zero.
// (R10) Each mask bit enables the status byte bit at that position.
// (R11) Mask readback lies in 0-63 or 128-191.
// (R12) Status query returns bits 0-5, 7 with summary in bit 6.
// (R13) Summary is OR of status AND mask, excluding bit 6.
// (R14) Bit 4 set while an output message is ready.
// (R15) Bit 5 summarises enabled standard events.
// (R16) Bit 3 summarises questionable status.
// (R17) Bit 7 summarises operation status; device bit summarises device status.
// (R18) Trigger command triggers waiting channels like a bus trigger.
// (R19) Trigger is ignored with error -211 if source not bus or none waiting.
// (R20) Self test runs about 30 s, then queues 0 pass, 1 fail.
// (R21) Wait holds later commands until operations finish or device clear.
// (R22) Reading standard event register returns it then clears it.
// (R23) After reset, triggers perform a plain trigger unless redefined.
// (R24) Bit 2 set while the error queue holds entries.
`timescale 1ns/10ps
`default_nettype none
module ccs_unit #(
    parameter logic [31:0] TEST_CYCLES = 32'(ccs_pkg::TEST_CYC_L),
    parameter logic [7:0] MAKER_CHAR = 8'h4D, // Arbitrary value
    parameter logic [7:0] MODEL_CHAR = 8'h31, // Arbitrary value
    parameter logic [7:0] FW_MAJOR = 8'h31, // Arbitrary value
    parameter logic [7:0] FW_MINOR = 8'h30 // Arbitrary value
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire ccs_pkg::cmd_req_t cmd,
    output logic out_valid,
    input wire logic out_ready,
    output logic [7:0] out_byte,
    output logic out_last,
    input wire logic [7:0] serial_char,
    input wire ccs_pkg::option_t option,
    input wire logic ops_pending,
    input wire logic device_clear,
    input wire logic [7:0] event_in,
    input wire logic [7:0] event_mask,
    input wire ccs_pkg::status_in_t sin,
    input wire logic trig_src_bus,
    input wire logic chan_waiting,
    input wire logic get_msg,
    input wire logic ddt_custom,
    output logic trig_pulse,
    output logic ddt_action,
    input wire logic [ccs_pkg::SETUP_W-1:0] setup_cur,
    output logic [ccs_pkg::SETUP_W-1:0] setup_q,
    output logic setup_load,
    input wire logic test_fail,
    output logic test_busy,
    output ccs_pkg::err_t err,
    output logic [7:0] srmask,
    output logic [7:0] stb,
    output logic mss
);
    typedef enum logic [2:0] {
        S_IDLE, S_WAIT_OPS, S_TEST, S_SEND
    } state_t;

    localparam int MSG_MAX = 12;

    state_t state_q;
    ccs_pkg::cmd_t pend_q;
    logic [7:0] msg_q [MSG_MAX];
    logic [3:0] len_q;
    logic [3:0] idx_q;
    logic [7:0] evt_q;
    logic [31:0] tcnt_q;
    logic [ccs_pkg::SETUP_W-1:0] slot_q [ccs_pkg::SLOTS];
    logic [ccs_pkg::SLOTS-1:0] used_q;
    logic [ccs_pkg::SETUP_W-1:0] setup_r;
    logic load_q;
    logic trig_q;
    logic ddt_q;
    ccs_pkg::err_t err_q;

    wire take = cmd_valid && cmd_ready;
    wire slot_ok = cmd.arg[3:0] >= ccs_pkg::SLOT_MIN
        && cmd.arg[3:0] <= ccs_pkg::SLOT_MAX && cmd.arg[7:4] == 4'h0;
    wire [3:0] slot_ix = cmd.arg[3:0] - ccs_pkg::SLOT_MIN;
    wire slot_full = slot_ok && used_q[slot_ix];
    wire esb = |(evt_q & event_mask); // R15
    wire ops_done = !ops_pending;
    wire trig_ok = trig_src_bus && chan_waiting;
    wire is_trg = take && cmd.cmd == ccs_pkg::CMD_TRG;
    wire do_trig = (is_trg || get_msg) && trig_ok; // R18 R19
    wire opc_set = state_q == S_WAIT_OPS && pend_q == ccs_pkg::CMD_OPC
        && ops_done; // R2
    wire esr_read = take && cmd.cmd == ccs_pkg::CMD_ESRQ;
    wire sending = state_q == S_SEND;
    ccs_pkg::status_in_t sin_int;

    // Converts a byte into three decimal digits
    function automatic logic [23:0] dec3(input logic [7:0] v);
        logic [7:0] h;
        logic [7:0] t;
        logic [7:0] o;
        h = v / 8'd100;
        t = (v % 8'd100) / 8'd10;
        o = v % 8'd10;
        return {ccs_pkg::CH_ZERO + h, ccs_pkg::CH_ZERO + t,
            ccs_pkg::CH_ZERO + o};
    endfunction : dec3

    always_comb
    begin
        sin_int = sin;
        sin_int.mav = sin.mav || sending; // R14
        sin_int.evq_nonempty = sin.evq_nonempty || err_q.valid; // R24
    end

    ccs_status_byte u_sb (
        .mclk(mclk),
        .rstn(rstn),
        .mask_we(take && cmd.cmd == ccs_pkg::CMD_SRE),
        .mask_wdata(cmd.arg),
        .clear_mask(1'b0),
        .sin(sin_int),
        .esb(esb),
        .mask(srmask),
        .stb(stb),
        .mss(mss)
    );

    assign cmd_ready = state_q == S_IDLE;
    assign out_valid = sending;
    assign out_byte = msg_q[idx_q];
    assign out_last = sending && idx_q + 4'h1 == len_q;
    assign setup_q = setup_r;
    assign setup_load = load_q;
    assign trig_pulse = trig_q;
    assign ddt_action = ddt_q;
    assign err = err_q;
    assign test_busy = state_q == S_TEST;

    // Sequencer
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            state_q <= S_IDLE;
        else if (device_clear)
            state_q <= S_IDLE; // R21
        else
            unique case (state_q)
                S_IDLE:
                    if (take)
                        unique case (cmd.cmd)
                            ccs_pkg::CMD_OPC, ccs_pkg::CMD_OPCQ,
                            ccs_pkg::CMD_WAI:
                                state_q <= S_WAIT_OPS; // R21
                            ccs_pkg::CMD_TSTQ:
                                state_q <= S_TEST; // R20
                            ccs_pkg::CMD_IDN, ccs_pkg::CMD_OPT,
                            ccs_pkg::CMD_SREQ, ccs_pkg::CMD_STBQ,
                            ccs_pkg::CMD_ESRQ:
                                state_q <= S_SEND;
                            default:
                                state_q <= S_IDLE;
                        endcase
                S_WAIT_OPS:
                    if (ops_done)
                        state_q <= pend_q == ccs_pkg::CMD_OPCQ
                            ? S_SEND : S_IDLE; // R3
                S_TEST:
                    if (tcnt_q + 32'h1 >= TEST_CYCLES)
                        state_q <= S_SEND; // R20
                S_SEND:
                    if (out_ready && out_last)
                        state_q <= S_IDLE;
                default:
                    state_q <= S_IDLE;
            endcase
    end

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            pend_q <= ccs_pkg::CMD_NOP;
        else if (take)
            pend_q <= cmd.cmd;
    end

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            tcnt_q <= 32'h0;
        else if (state_q == S_TEST)
            tcnt_q <= tcnt_q + 32'h1;
        else
            tcnt_q <= 32'h0;
    end

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            idx_q <= 4'h0;
        else if (!sending)
            idx_q <= 4'h0;
        else if (out_ready && !out_last)
            idx_q <= idx_q + 4'h1;
    end

    // Standard event register: set wins over read clear
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            evt_q <= ccs_pkg::EVT_RESET;
        else
            evt_q <= (esr_read ? 8'h00 : evt_q) | event_in
                | ({7'h00, opc_set} << ccs_pkg::E_OPC); // R2 R22
    end

    // Response message assembly
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            len_q <= 4'h0;
            for (int i = 0; i < MSG_MAX; i++)
                msg_q[i] <= ccs_pkg::CH_NUL;
        end
        else if (take)
        begin
            unique case (cmd.cmd)
                ccs_pkg::CMD_IDN:
                begin
                    msg_q[0] <= MAKER_CHAR; // R1
                    msg_q[1] <= ccs_pkg::CH_COMMA;
                    msg_q[2] <= MODEL_CHAR;
                    msg_q[3] <= ccs_pkg::CH_COMMA;
                    msg_q[4] <= serial_char;
                    msg_q[5] <= ccs_pkg::CH_COMMA;
                    msg_q[6] <= FW_MAJOR;
                    msg_q[7] <= ccs_pkg::CH_DOT;
                    msg_q[8] <= FW_MINOR;
                    len_q <= 4'h9;
                end
                ccs_pkg::CMD_OPT:
                begin
                    msg_q[0] <= ccs_pkg::CH_ZERO; // R4
                    msg_q[1] <= ccs_pkg::CH_ZERO;
                    msg_q[2] <= option == ccs_pkg::OPT_003
                        ? ccs_pkg::CH_THREE : ccs_pkg::CH_TWO;
                    len_q <= option == ccs_pkg::OPT_STD ? 4'h1 : 4'h3;
                    if (option == ccs_pkg::OPT_STD)
                        msg_q[0] <= ccs_pkg::CH_NUL;
                end
                ccs_pkg::CMD_SREQ:
                begin
                    {msg_q[0], msg_q[1], msg_q[2]} <= dec3(srmask); // R11
                    len_q <= 4'h3;
                end
                ccs_pkg::CMD_STBQ:
                begin
                    {msg_q[0], msg_q[1], msg_q[2]} <= dec3(stb); // R12
                    len_q <= 4'h3;
                end
                ccs_pkg::CMD_ESRQ:
                begin
                    {msg_q[0], msg_q[1], msg_q[2]} <= dec3(evt_q); // R22
                    len_q <= 4'h3;
                end
                ccs_pkg::CMD_OPCQ:
                begin
                    msg_q[0] <= ccs_pkg::CH_ONE; // R3
                    len_q <= 4'h1;
                end
                default:
                    len_q <= len_q;
            endcase
        end
        else if (state_q == S_TEST && tcnt_q + 32'h1 >= TEST_CYCLES)
        begin
            msg_q[0] <= test_fail ? ccs_pkg::CH_ONE
                : ccs_pkg::CH_ZERO; // R20
            len_q <= 4'h1;
        end
    end

    // Save/recall store and live setup
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            used_q <= '0;
            setup_r <= ccs_pkg::SETUP_DEFAULT;
            load_q <= 1'b0;
            for (int i = 0; i < ccs_pkg::SLOTS; i++)
                slot_q[i] <= ccs_pkg::SETUP_DEFAULT;
        end
        else
        begin
            load_q <= 1'b0;
            if (take && cmd.cmd == ccs_pkg::CMD_SAV && slot_ok)
            begin
                slot_q[slot_ix] <= setup_cur; // R7
                used_q[slot_ix] <= 1'b1;
            end
            if (take && cmd.cmd == ccs_pkg::CMD_RCL && slot_full)
            begin
                setup_r <= slot_q[slot_ix]; // R5
                load_q <= 1'b1;
            end
            if (take && cmd.cmd == ccs_pkg::CMD_RST)
            begin
                setup_r <= ccs_pkg::SETUP_DEFAULT; // R8
                load_q <= 1'b1;
            end
        end
    end

    // Trigger action and error report
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            trig_q <= 1'b0;
            ddt_q <= 1'b0;
            err_q <= '0;
        end
        else
        begin
            trig_q <= do_trig && !ddt_custom; // R23
            ddt_q <= do_trig && ddt_custom; // R23
            err_q.valid <= 1'b0;
            if ((is_trg || get_msg) && !trig_ok)
            begin
                err_q.code <= ccs_pkg::ERR_TRIG; // R19
                err_q.valid <= 1'b1;
            end
            else if (take && (cmd.cmd == ccs_pkg::CMD_RCL
                || cmd.cmd == ccs_pkg::CMD_SAV) && !slot_full
                && !(cmd.cmd == ccs_pkg::CMD_SAV && slot_ok))
            begin
                err_q.code <= ccs_pkg::ERR_PARAM; // R6
                err_q.valid <= 1'b1;
            end
        end
    end
endmodule : ccs_unit
`default_nettype wire

// ===== verif/ccs_host_model.sv
// Bus controller model that takes reply bytes
`timescale 1ns/10ps
`default_nettype none
module ccs_host_model (
    input wire logic mclk,
    input wire logic slow,
    input wire logic clr,
    input wire logic out_valid,
    input wire logic [7:0] out_byte,
    input wire logic out_last,
    output logic out_ready
);
    logic [7:0] rx [0:15];
    int n = 0;
    logic done = 1'b0;
    initial out_ready = 1'b0;
    // Slow mode stalls every other cycle
    always @(negedge mclk)
        out_ready <= slow ? !out_ready : 1'b1;
    always @(posedge mclk)
    begin
        if (clr)
        begin
            n <= 0;
            done <= 1'b0;
        end
        else if (out_valid && out_ready)
        begin
            rx[n[3:0]] <= out_byte;
            n <= n + 1;
            done <= out_last;
        end
    end
endmodule : ccs_host_model
`default_nettype wire

// ===== verif/ccs_unit_props.sv
// Port checks of the common command unit
`timescale 1ns/10ps
`default_nettype none
module ccs_unit_props (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic cmd_valid,
    input wire logic cmd_ready,
    input wire ccs_pkg::cmd_req_t cmd,
    input wire logic out_valid,
    input wire logic ops_pending,
    input wire ccs_pkg::status_in_t sin,
    input wire logic trig_src_bus,
    input wire logic chan_waiting,
    input wire logic ddt_custom,
    input wire logic trig_pulse,
    input wire logic test_busy,
    input wire ccs_pkg::err_t err,
    input wire logic [7:0] srmask,
    input wire logic [7:0] stb,
    input wire logic mss
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);
    wire logic take = cmd_valid && cmd_ready;
    wire logic trg_ok = trig_src_bus && chan_waiting;
    sequence s_take_opcq;
        take && cmd.cmd == ccs_pkg::CMD_OPCQ;
    endsequence
    sequence s_take_trg;
        take && cmd.cmd == ccs_pkg::CMD_TRG;
    endsequence
    a_mask_write_keep: assert property (take && cmd.cmd == ccs_pkg::CMD_SRE
        |=> srmask == ($past(cmd.arg) & ccs_pkg::MASK_KEEP))
        else $error("mask write not stored");
    a_mask_bit_six: assert property (srmask[6] == 1'b0)
        else $error("mask bit 6 set");
    a_summary_or: assert property (mss == |(stb & srmask & 8'hBF))
        else $error("summary not OR of enabled bits");
    a_stb_summary: assert property (stb[6] == mss)
        else $error("status bit 6 not summary");
    a_stb_map: assert property (stb[3] == sin.ques && stb[7] == sin.oper
        && stb[1] == sin.devdep && stb[2] == (sin.evq_nonempty || err.valid)
        && (!sin.mav || stb[4]))
        else $error("status bit map wrong");
    a_rcl_range: assert property (take && cmd.cmd == ccs_pkg::CMD_RCL
        && (cmd.arg == 8'h00 || cmd.arg > 8'h0A)
        |=> err.valid && err.code == ccs_pkg::ERR_PARAM)
        else $error("bad slot not refused");
    a_trig_refuse: assert property (s_take_trg ##0 !trg_ok
        |=> err.valid && err.code == ccs_pkg::ERR_TRIG && !trig_pulse)
        else $error("trigger not refused");
    a_trig_fire: assert property (s_take_trg ##0 trg_ok && !ddt_custom
        |=> trig_pulse && !err.valid)
        else $error("trigger not fired");
    a_opc_hold: assert property (s_take_opcq ##0 ops_pending
        ##1 ops_pending [*2] |-> !out_valid)
        else $error("reply before operations done");
    a_test_busy: assert property (take && cmd.cmd == ccs_pkg::CMD_TSTQ
        |=> test_busy [*3])
        else $error("self test not busy");
endmodule : ccs_unit_props
bind ccs_unit ccs_unit_props u_props (.mclk(mclk), .rstn(rstn),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd(cmd),
    .out_valid(out_valid), .ops_pending(ops_pending), .sin(sin),
    .trig_src_bus(trig_src_bus), .chan_waiting(chan_waiting),
    .ddt_custom(ddt_custom), .trig_pulse(trig_pulse),
    .test_busy(test_busy), .err(err), .srmask(srmask), .stb(stb), .mss(mss));
`default_nettype wire

// ===== verif/common_command_status_unit_test.sv
// Self-checking bench of the common command unit
`timescale 1ns/10ps
`default_nettype none
module common_command_status_unit_test;
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    logic cmd_valid = 1'b0;
    logic slow = 1'b0;
    logic clr = 1'b0;
    logic ops_pending = 1'b0;
    logic device_clear = 1'b0;
    logic trig_src_bus = 1'b0;
    logic chan_waiting = 1'b0;
    logic get_msg = 1'b0;
    logic ddt_custom = 1'b0;
    logic test_fail = 1'b0;
    logic [7:0] event_mask = 8'h00;
    logic [7:0] event_in = 8'h00;
    logic [7:0] serial_char = 8'h37;
    logic [31:0] setup_cur = 32'h0;
    ccs_pkg::cmd_req_t cmd = '{ccs_pkg::CMD_NOP, 8'h00};
    ccs_pkg::option_t option = ccs_pkg::OPT_STD;
    ccs_pkg::status_in_t sin = '0;
    logic cmd_ready, out_valid, out_ready, out_last, trig_pulse, ddt_action;
    logic setup_load, test_busy, mss;
    logic [7:0] out_byte, srmask, stb;
    logic [31:0] setup_q;
    ccs_pkg::err_t err;
    logic [15:0] err_code = 16'h0;
    int trig_n = 0, ddt_n = 0, load_n = 0;
    int fail_count = 0;
    int samples_checked = 0;
    always #4 mclk = ~mclk;
    ccs_unit #(.TEST_CYCLES(32'h14), .FW_MINOR(8'h39)) u_ccs_unit (
        .mclk(mclk), .rstn(rstn), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .cmd(cmd), .out_valid(out_valid),
        .out_ready(out_ready), .out_byte(out_byte), .out_last(out_last),
        .serial_char(serial_char), .option(option),
        .ops_pending(ops_pending), .device_clear(device_clear),
        .event_in(event_in), .event_mask(event_mask), .sin(sin),
        .trig_src_bus(trig_src_bus), .chan_waiting(chan_waiting),
        .get_msg(get_msg), .ddt_custom(ddt_custom), .trig_pulse(trig_pulse),
        .ddt_action(ddt_action), .setup_cur(setup_cur), .setup_q(setup_q),
        .setup_load(setup_load), .test_fail(test_fail),
        .test_busy(test_busy), .err(err), .srmask(srmask), .stb(stb),
        .mss(mss));
    ccs_host_model u_host (.mclk(mclk), .slow(slow), .clr(clr),
        .out_valid(out_valid), .out_byte(out_byte), .out_last(out_last),
        .out_ready(out_ready));
    // Pulse outputs counted as they pass
    always @(posedge mclk)
    begin
        if (err.valid === 1'b1)
            err_code <= err.code;
        trig_n <= trig_n + int'(trig_pulse === 1'b1);
        ddt_n <= ddt_n + int'(ddt_action === 1'b1);
        load_n <= load_n + int'(setup_load === 1'b1);
    end
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : report_and_stop
    task automatic check(input string what, input logic [31:0] e,
        input logic [31:0] g);
        samples_checked++;
        if (g !== e)
        begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", what, e, g);
        end
    endtask : check
    task automatic send(input ccs_pkg::cmd_t c, input logic [7:0] a);
        int n;
        n = 0;
        @(negedge mclk);
        while (cmd_ready !== 1'b1 && n < 200)
        begin
            @(negedge mclk);
            n++;
        end
        cmd_valid = 1'b1;
        cmd = '{c, a};
        @(negedge mclk);
        cmd_valid = 1'b0;
    endtask : send
    task automatic start(input ccs_pkg::cmd_t c, input logic [7:0] a);
        clr = 1'b1;
        @(negedge mclk);
        clr = 1'b0;
        send(c, a);
    endtask : start
    task automatic finish_reply();
        int n;
        n = 0;
        while (u_host.done !== 1'b1 && n < 400)
        begin
            @(negedge mclk);
            n++;
        end
        check("reply end", 32'h1, 32'(u_host.done));
    endtask : finish_reply
    task automatic num(input ccs_pkg::cmd_t c, input logic [7:0] v);
        start(c, 8'h00);
        finish_reply();
        check("digits", {8'h00, 8'h30 + v / 8'd100,
            8'h30 + v / 8'd10 % 8'd10, 8'h30 + v % 8'd10},
            {8'h00, u_host.rx[0], u_host.rx[1], u_host.rx[2]});
    endtask : num
    task automatic settle(input logic [15:0] e);
        repeat (2) @(negedge mclk);
        check("error code", 32'(e), 32'(err_code));
        err_code = 16'h0;
    endtask : settle
    task automatic t_status();
        send(ccs_pkg::CMD_SRE, 8'hFF);
        check("mask", 32'hBF, 32'(srmask));
        slow = 1'b1;
        num(ccs_pkg::CMD_SREQ, 8'hBF);
        slow = 1'b0;
        sin = '1;
        send(ccs_pkg::CMD_SRE, 8'h00);
        check("stb none", 32'h9E, 32'(stb));
        sin = 5'h10;
        send(ccs_pkg::CMD_SRE, 8'h08);
        check("stb ques", 32'h48, 32'(stb));
        num(ccs_pkg::CMD_STBQ, 8'h48);
        sin = '0;
        event_mask = 8'h80;
        send(ccs_pkg::CMD_SRE, 8'h20);
        check("stb event", 32'h60, 32'(stb));
        num(ccs_pkg::CMD_ESRQ, 8'h80);
        @(negedge mclk);
        check("stb cleared", 32'h00, 32'(stb));
    endtask : t_status
    task automatic t_opc();
        ops_pending = 1'b1;
        start(ccs_pkg::CMD_OPCQ, 8'h00);
        repeat (4) @(negedge mclk);
        check("early bytes", 32'h0, 32'(u_host.n));
        ops_pending = 1'b0;
        finish_reply();
        check("opc reply", 32'h31, 32'(u_host.rx[u_host.n - 1]));
        ops_pending = 1'b1;
        send(ccs_pkg::CMD_OPC, 8'h00);
        repeat (3) @(negedge mclk);
        ops_pending = 1'b0;
        repeat (3) @(negedge mclk);
        num(ccs_pkg::CMD_ESRQ, 8'h01);
    endtask : t_opc
    task automatic t_slots();
        send(ccs_pkg::CMD_RCL, 8'h03);
        settle(ccs_pkg::ERR_PARAM);
        send(ccs_pkg::CMD_RCL, 8'h0B);
        settle(ccs_pkg::ERR_PARAM);
        setup_cur = 32'h1111_2222;
        send(ccs_pkg::CMD_SAV, 8'h03);
        setup_cur = 32'hA5C3_0F1E;
        send(ccs_pkg::CMD_SAV, 8'h0A);
        setup_cur = 32'h5A3C_F0E1;
        send(ccs_pkg::CMD_SAV, 8'h03);
        send(ccs_pkg::CMD_RCL, 8'h0A);
        settle(16'h0);
        check("setup ten", 32'hA5C3_0F1E, setup_q);
        send(ccs_pkg::CMD_RCL, 8'h03);
        settle(16'h0);
        check("setup three", 32'h5A3C_F0E1, setup_q);
        check("loads", 32'h2, 32'(load_n));
        send(ccs_pkg::CMD_RST, 8'h00);
        settle(16'h0);
        check("setup default", ccs_pkg::SETUP_DEFAULT, setup_q);
    endtask : t_slots
    task automatic t_trig();
        chan_waiting = 1'b1;
        send(ccs_pkg::CMD_TRG, 8'h00);
        settle(ccs_pkg::ERR_TRIG);
        trig_src_bus = 1'b1;
        chan_waiting = 1'b0;
        send(ccs_pkg::CMD_TRG, 8'h00);
        settle(ccs_pkg::ERR_TRIG);
        chan_waiting = 1'b1;
        send(ccs_pkg::CMD_TRG, 8'h00);
        settle(16'h0);
        get_msg = 1'b1;
        @(negedge mclk);
        get_msg = 1'b0;
        repeat (2) @(negedge mclk);
        check("triggers", 32'h2, 32'(trig_n));
        ddt_custom = 1'b1;
        send(ccs_pkg::CMD_TRG, 8'h00);
        settle(16'h0);
        check("redefined", 32'h1, 32'(ddt_n));
        ddt_custom = 1'b0;
    endtask : t_trig
    task automatic t_query();
        start(ccs_pkg::CMD_OPT, 8'h00);
        finish_reply();
        check("std option", 32'h0, {u_host.rx[0], 24'(u_host.n) - 24'h1});
        option = ccs_pkg::OPT_002;
        num(ccs_pkg::CMD_OPT, 8'h02);
        option = ccs_pkg::OPT_003;
        num(ccs_pkg::CMD_OPT, 8'h03);
        start(ccs_pkg::CMD_IDN, 8'h00);
        finish_reply();
        check("ident", 32'h2C37_2E39, {u_host.rx[3], u_host.rx[4],
            u_host.rx[u_host.n - 2], u_host.rx[u_host.n - 1]});
        test_fail = 1'b1;
        start(ccs_pkg::CMD_TSTQ, 8'h00);
        check("busy", 32'h1, 32'(test_busy));
        finish_reply();
        check("test fail", 32'h31, 32'(u_host.rx[u_host.n - 1]));
        test_fail = 1'b0;
        start(ccs_pkg::CMD_TSTQ, 8'h00);
        finish_reply();
        check("test pass", 32'h30, 32'(u_host.rx[u_host.n - 1]));
    endtask : t_query
    task automatic t_wait();
        ops_pending = 1'b1;
        send(ccs_pkg::CMD_WAI, 8'h00);
        repeat (3) @(negedge mclk);
        check("held", 32'h0, 32'(cmd_ready));
        device_clear = 1'b1;
        @(negedge mclk);
        device_clear = 1'b0;
        repeat (2) @(negedge mclk);
        check("released", 32'h1, 32'(cmd_ready));
        ops_pending = 1'b0;
    endtask : t_wait
    initial
    begin
        repeat (12) @(posedge mclk);
        @(negedge mclk);
        rstn = 1'b1;
        t_status();
        t_opc();
        t_slots();
        t_trig();
        t_query();
        t_wait();
        report_and_stop();
    end
    initial
    begin
        #160000;
        fail_count++;
        report_and_stop();
    end
endmodule : common_command_status_unit_test
`default_nettype wire
